// ### oms_pkg.sv
// Purpose: shared constants and types for the or/move/skip decode block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   opcode fields sit in instruction bits 13:8
package oms_pkg;

  localparam int OMS_IW      = 14;
  localparam int OMS_DW      = 8;
  localparam int OMS_FAW     = 7;
  localparam int OMS_PCW     = 13;
  localparam int OMS_FDEPTH  = 128;

  localparam logic [5:0]        OMS_OP_OR_FILE  = 6'h04;
  localparam logic [5:0]        OMS_OP_COPY     = 6'h08;
  localparam logic [5:0]        OMS_OP_INC_SKIP = 6'h0f;
  localparam logic [3:0]        OMS_OP_LIT      = 4'hc;
  localparam logic [OMS_IW-1:0] OMS_NOP_WORD    = 14'h0000;

  localparam logic [OMS_PCW-1:0] OMS_PC_RESET   = 13'h0000;
  localparam logic [OMS_DW-1:0]  OMS_ACC_RESET  = 8'h00;
  localparam logic               OMS_ZERO_RESET = 1'b0;
  localparam logic               OMS_DEST_ACC   = 1'b0;

  typedef enum logic [2:0] {
    OMS_K_NONE,
    OMS_K_OR_FILE,
    OMS_K_LIT,
    OMS_K_COPY,
    OMS_K_INC_SKIP
  } oms_kind_t;

  // one decoded instruction word
  typedef struct packed {
    oms_kind_t             kind;
    logic                  dest;
    logic [OMS_FAW-1:0]    faddr;
    logic [OMS_DW-1:0]     lit;
  } oms_insn_t;

  // one file register write
  typedef struct packed {
    logic                  en;
    logic [OMS_FAW-1:0]    addr;
    logic [OMS_DW-1:0]     data;
  } oms_fwr_t;

  // instruction cycle phases, gray along the loop
  typedef enum logic {
    OMS_PH_READ = 1'b0,
    OMS_PH_EXEC = 1'b1
  } oms_phase_t;

endpackage

// ### oms_file_mem.sv
// Purpose: file register space, synchronous write, registered read
// Assumes: one read and one write port on the core clock
// Notes:   contents are not reset
`timescale 1ns/100ps
module oms_file_mem #(
  parameter int DEPTH = 128,
  parameter int AW    = 7,
  parameter int DW    = 8
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output      logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ### oms_core.sv
// Purpose: decode and execute or-into-file, load-literal, copy-file, increment-skip
// Assumes: program memory answers prog_addr within one clock, same clock domain
// Notes:   an instruction cycle is two clocks; other opcodes run as no-operation
// How it works
// (RQ1) or-into-file ORs accumulator with file register, zero flag follows result
// (RQ2) or-into-file result goes to accumulator if dest 0, file if 1
// (RQ3) load-literal puts 8-bit immediate in accumulator, flags untouched
// (RQ4) code supplier passes the two don't-care bits through as stored; decoder ignores them (the bench stores them nonzero in word 5)
// (RQ5) copy-file reads file register, sends it to accumulator when dest 0
// (RQ6) copy-file with dest 1 writes the same value back into the file
// (RQ7) copy-file sets zero flag from the moved value
// (RQ8) increment-skip adds one to file register, skips next instruction on zero
// (RQ9) taken skip discards prefetched word and runs a no-operation instead
// (RQ10) these instructions are one word, one instruction cycle, 7-bit file address
`timescale 1ns/100ps
module oms_core #(
  parameter int PCW = oms_pkg::OMS_PCW
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // program memory
  output      logic [PCW-1:0]                prog_addr_r,
  input  wire logic [oms_pkg::OMS_IW-1:0]    prog_data,
  // architectural state
  output      logic [oms_pkg::OMS_DW-1:0]    acc_r,
  output      logic                          zero_r,
  // file write echo
  output      oms_pkg::oms_fwr_t             fwr_r
);
  import oms_pkg::*;

  function automatic oms_insn_t oms_decode(input logic [OMS_IW-1:0] w);
    oms_insn_t d;
    d.dest  = w[7];
    d.faddr = w[OMS_FAW-1:0];
    d.lit   = w[OMS_DW-1:0];
    if (w[13:10] == OMS_OP_LIT) begin
      d.kind = OMS_K_LIT; // RQ4
    end else if (w[13:8] == OMS_OP_OR_FILE) begin
      d.kind = OMS_K_OR_FILE;
    end else if (w[13:8] == OMS_OP_COPY) begin
      d.kind = OMS_K_COPY;
    end else if (w[13:8] == OMS_OP_INC_SKIP) begin
      d.kind = OMS_K_INC_SKIP;
    end else begin
      d.kind = OMS_K_NONE;
    end
    return d;
  endfunction

  function automatic logic oms_is_zero(input logic [OMS_DW-1:0] v);
    return v == '0;
  endfunction

  oms_phase_t          phase_r;
  logic [OMS_IW-1:0]   ir_r;
  oms_insn_t           dec;
  logic [OMS_DW-1:0]   fdata;
  logic [OMS_DW-1:0]   result;
  logic                exec;
  logic                skip;
  logic                to_file;
  logic                to_acc;
  logic                sets_zero;

  assign dec  = oms_decode(ir_r);
  assign exec = (phase_r == OMS_PH_EXEC);

  oms_file_mem #(
    .DEPTH (OMS_FDEPTH),
    .AW    (OMS_FAW),
    .DW    (OMS_DW)
  ) u_fmem (
    .clk     (clk),
    .wr_en   (exec && to_file),
    .wr_addr (dec.faddr),
    .wr_data (result),
    .rd_addr (dec.faddr),
    .rd_data (fdata)
  );

  // result and destination of the instruction in ir_r
  always_comb begin
    result    = '0;
    to_file   = 1'b0;
    to_acc    = 1'b0;
    sets_zero = 1'b0;
    skip      = 1'b0;
    case (dec.kind)
      OMS_K_OR_FILE: begin
        result    = acc_r | fdata; // RQ1
        to_acc    = (dec.dest == OMS_DEST_ACC); // RQ2
        to_file   = (dec.dest != OMS_DEST_ACC); // RQ2
        sets_zero = 1'b1; // RQ1
      end
      OMS_K_LIT: begin
        result = dec.lit; // RQ3
        to_acc = 1'b1; // RQ3
      end
      OMS_K_COPY: begin
        result    = fdata; // RQ5
        to_acc    = (dec.dest == OMS_DEST_ACC); // RQ5
        to_file   = (dec.dest != OMS_DEST_ACC); // RQ6
        sets_zero = 1'b1; // RQ7
      end
      OMS_K_INC_SKIP: begin
        result  = fdata + 8'h01; // RQ8
        to_acc  = (dec.dest == OMS_DEST_ACC);
        to_file = (dec.dest != OMS_DEST_ACC);
        skip    = oms_is_zero(result); // RQ8
      end
      default: begin
        result = '0;
      end
    endcase
  end

  // two-clock instruction cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= OMS_PH_READ;
    end else begin
      case (phase_r)
        OMS_PH_READ: phase_r <= OMS_PH_EXEC;
        OMS_PH_EXEC: phase_r <= OMS_PH_READ;
        default:     phase_r <= OMS_PH_READ;
      endcase
    end
  end

  // fetch: prefetched word becomes next instruction unless skipped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_r        <= OMS_NOP_WORD;
      prog_addr_r <= OMS_PC_RESET;
    end else if (exec) begin
      ir_r        <= skip ? OMS_NOP_WORD : prog_data; // RQ9
      prog_addr_r <= prog_addr_r + {{(PCW-1){1'b0}}, 1'b1}; // RQ10
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= OMS_ACC_RESET;
    end else if (exec && to_acc) begin
      acc_r <= result;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_r <= OMS_ZERO_RESET;
    end else if (exec && sets_zero) begin
      zero_r <= oms_is_zero(result); // RQ1
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fwr_r <= '0;
    end else begin
      fwr_r.en   <= exec && to_file;
      fwr_r.addr <= dec.faddr;
      fwr_r.data <= result;
    end
  end

  // checks
  a_or_acc_value: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
    exec && dec.kind == OMS_K_OR_FILE && !dec.dest |=> acc_r == ($past(acc_r) | $past(fdata)))
    else $error("or into accumulator wrong");
  a_or_file_dest: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    exec && dec.kind == OMS_K_OR_FILE && dec.dest |=> fwr_r.en && $stable(acc_r)
      && fwr_r.data == ($past(acc_r) | $past(fdata)))
    else $error("or into file wrong");
  a_or_zero_flag: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
    exec && dec.kind == OMS_K_OR_FILE |=> zero_r == (($past(acc_r) | $past(fdata)) == 8'h00))
    else $error("or zero flag wrong");
  a_lit_load: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
    exec && ir_r[13:10] == OMS_OP_LIT |=> acc_r == $past(ir_r[7:0]) && $stable(zero_r)
      && !fwr_r.en)
    else $error("literal load wrong");
  a_copy_acc: assert property (@(posedge clk) disable iff (!rst_b) // RQ5
    exec && dec.kind == OMS_K_COPY && !dec.dest |=> acc_r == $past(fdata) && !fwr_r.en)
    else $error("copy to accumulator wrong");
  a_copy_file: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
    exec && dec.kind == OMS_K_COPY && dec.dest |=> fwr_r.en && fwr_r.data == $past(fdata)
      && $stable(acc_r))
    else $error("copy back to file wrong");
  a_copy_zero: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
    exec && dec.kind == OMS_K_COPY |=> zero_r == ($past(fdata) == 8'h00))
    else $error("copy zero flag wrong");
  a_inc_result: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
    exec && dec.kind == OMS_K_INC_SKIP && dec.dest |=> fwr_r.en
      && fwr_r.data == 8'($past(fdata) + 8'h01) && $stable(zero_r))
    else $error("increment result wrong");
  a_skip_flush: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
    exec && dec.kind == OMS_K_INC_SKIP && fdata == 8'hff |=> ir_r == OMS_NOP_WORD)
    else $error("skip did not discard next word");
  a_noskip_fetch: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
    exec && dec.kind == OMS_K_INC_SKIP && fdata != 8'hff |=> ir_r == $past(prog_data))
    else $error("no-skip lost next word");
  a_cycle_step: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
    exec |=> !exec && prog_addr_r == PCW'($past(prog_addr_r) + 1) ##1 exec)
    else $error("instruction cycle not two clocks");
  a_inc_acc: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
    exec && dec.kind == OMS_K_INC_SKIP && !dec.dest |=> !fwr_r.en
      && acc_r == 8'($past(fdata) + 8'h01) && $stable(zero_r))
    else $error("increment into accumulator wrong");
  a_nop_quiet: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
    exec && dec.kind == OMS_K_NONE |=> !fwr_r.en && $stable(acc_r) && $stable(zero_r))
    else $error("no-operation changed state");

  c_or_file:   cover property (@(posedge clk) disable iff (!rst_b)
    exec && dec.kind == OMS_K_OR_FILE && dec.dest);
  c_lit:       cover property (@(posedge clk) disable iff (!rst_b) exec && dec.kind == OMS_K_LIT);
  c_copy_test: cover property (@(posedge clk) disable iff (!rst_b)
    exec && dec.kind == OMS_K_COPY && dec.dest && fdata == 8'h00);
  c_skip:      cover property (@(posedge clk) disable iff (!rst_b) exec && skip);
  c_no_skip:   cover property (@(posedge clk) disable iff (!rst_b)
    exec && dec.kind == OMS_K_INC_SKIP && !skip);
endmodule

// ### oms_prog_model.sv
// Purpose: program memory partner for the decode block
// Assumes: word for prog_addr is needed only at the next execute edge
// Notes:   slow answer, registered one clock late; the bench loads every word
`timescale 1ns/100ps
module oms_prog_model #(
  parameter int DEPTH = 32
) (
  // clock
  input  wire logic                        clk,
  // fetch
  input  wire logic [oms_pkg::OMS_PCW-1:0] prog_addr,
  output      logic [oms_pkg::OMS_IW-1:0]  prog_data
);
  import oms_pkg::*;

  // literal don't-care bits are stored as the bench writes them
  logic [OMS_IW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    prog_data <= (prog_addr < DEPTH) ? mem[prog_addr] : OMS_NOP_WORD;
  end
endmodule

// ### or_move_skip_decode_tb.sv
// Purpose: self-checking bench for the or/move/skip decode block
// Assumes: one instruction per two clocks, first word executes at edge 4 after release
// Notes:   file cell 0x10 is seeded by or and increment, since it is not reset
`timescale 1ns/100ps
module or_move_skip_decode_tb;
  import oms_pkg::*;

  // word 5 carries nonzero literal don't-care bits
  localparam logic [OMS_IW-1:0] PROG [13] = '{
    14'h30ff, 14'h0490, 14'h0f90, 14'h3011, 14'h0810, 14'h3391, 14'h0490,
    14'h3013, 14'h0410, 14'h0890, 14'h0f10, 14'h3000, 14'h0890};

  logic               clk;
  logic               rst_b;
  logic [OMS_PCW-1:0] prog_addr;
  logic [OMS_IW-1:0]  prog_data;
  logic [OMS_DW-1:0]  acc;
  logic               zero;
  oms_fwr_t           fwr;
  int                 errors;
  int                 check_count;
  int                 pc_exp;

  oms_core dut (.clk(clk), .rst_b(rst_b), .prog_addr_r(prog_addr),
    .prog_data(prog_data), .acc_r(acc), .zero_r(zero), .fwr_r(fwr));

  oms_prog_model pm (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data));

  always #5 clk = ~clk;

  task automatic complete_run();
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one instruction cycle, then compare what it left behind
  task automatic step(input logic [7:0] a, input logic z, input logic we, input logic [7:0] d);
    repeat (2) @(posedge clk);
    #1;
    pc_exp++;
    chk("acc", {8'h00, a}, {8'h00, acc});
    chk("zero", {15'h0000, z}, {15'h0000, zero});
    chk("fwr_en", {15'h0000, we}, {15'h0000, fwr.en});
    if (we === 1'b1) begin
      chk("fwr_addr", 16'h0010, {9'h000, fwr.addr});
      chk("fwr_data", {8'h00, d}, {8'h00, fwr.data});
    end
    chk("prog_addr", pc_exp[15:0], {3'h0, prog_addr});
  endtask

  task automatic t_literal();
    step(8'hff, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_or_to_file();
    step(8'hff, 1'b0, 1'b1, 8'hff);
  endtask

  // ff + 1 wraps to zero, so the literal 0x11 behind it must vanish
  task automatic t_skip_taken();
    step(8'hff, 1'b0, 1'b1, 8'h00);
    step(8'hff, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_copy_to_acc();
    step(8'h00, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic t_literal_dont_care();
    step(8'h91, 1'b1, 1'b0, 8'h00);
  endtask

  // 0x91 into the file, then 0x13 | 0x91 into the accumulator only
  task automatic t_or_dest();
    step(8'h91, 1'b0, 1'b1, 8'h91);
    step(8'h13, 1'b0, 1'b0, 8'h00);
    step(8'h93, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_copy_to_file();
    step(8'h93, 1'b0, 1'b1, 8'h91);
  endtask

  // 0x91 + 1 is nonzero: no skip, next literal runs, zero flag kept
  task automatic t_skip_not_taken();
    step(8'h92, 1'b0, 1'b0, 8'h00);
    step(8'h00, 1'b0, 1'b0, 8'h00);
    step(8'h00, 1'b0, 1'b1, 8'h91);
  endtask

  initial begin
    #3000;
    errors++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    errors = 0;
    check_count = 0;
    pc_exp = 1;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      if (i < 13) begin
        pm.mem[i] = PROG[i];
      end else begin
        pm.mem[i] = OMS_NOP_WORD;
      end
    end
    #1;
    chk("acc_reset", 16'h0000, {8'h00, acc});
    chk("zero_reset", 16'h0000, {15'h0000, zero});
    chk("fwr_reset", 16'h0000, fwr);
    chk("pc_reset", 16'h0000, {3'h0, prog_addr});
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_literal();
    t_or_to_file();
    t_skip_taken();
    t_copy_to_acc();
    t_literal_dont_care();
    t_or_dest();
    t_copy_to_file();
    t_skip_not_taken();
    complete_run();
  end
endmodule
